// *** logic/asp_pkg.sv ***
// Constants and types for the asynchronous serial port
`default_nettype none
package asp_pkg;
    localparam int unsigned FRAME_SEL_BIT = 7;
    localparam int unsigned MP_EN_BIT = 5;
    localparam int unsigned RX_EN_BIT = 4;
    localparam int unsigned TX_NINTH_BIT = 3;
    localparam int unsigned RX_NINTH_BIT = 2;
    localparam int unsigned TX_DONE_BIT = 1;
    localparam int unsigned RX_DONE_BIT = 0;
    localparam int unsigned CTRL_W = 8;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] BUF_RESET = 8'h00;
    localparam int unsigned DATA_BITS = 8;
    localparam int unsigned OVERSAMPLE = 16;
    localparam int unsigned SAMPLE_POINT = 8;
    typedef enum logic [2:0] {ASP_IDLE, ASP_START, ASP_DATA, ASP_NINTH, ASP_STOP} asp_state_t;
endpackage
`default_nettype wire

// *** logic/asp_serial_port.sv ***
// Full-duplex asynchronous serial port with 8-bit and 9-bit framing
// Notes on behaviour
// - frame_width_select (control bit 7) picks 8-bit or 9-bit framing both ways.
// - 8-bit frame: start, eight data bits LSB first, stop; ten bit times.
// - Writing the serial buffer while idle starts transmission immediately; writes mid-frame are dropped.
// - tx_done_flag sets at the start of the stop bit.
// - Frames are received only while rx_enable is 1.
// - 8-bit accept stores byte, stop bit to rx_ninth_bit, sets flag.
// - Rejected frames leave buffer, rx_ninth_bit and rx_done_flag unchanged.
// - On overrun the first byte stays; later frames are discarded.
// - Interrupt request when enabled and either done flag is set.
// - 9-bit frame: start, eight data LSB first, ninth bit, stop; eleven bit times.
// - 9-bit transmit sends tx_ninth_bit (control bit 3) as ninth bit.
// - 9-bit receive puts ninth bit in rx_ninth_bit, stop bit ignored.
// - 9-bit accept needs flag 0 and, with multiproc_enable, ninth bit 1.
// - multiproc_enable bit 5, rx_enable bit 4, tx_done_flag bit 1.
`timescale 1ns/100ps
`default_nettype none
module asp_serial_port
    import asp_pkg::*;
#(
    parameter int unsigned OVS = asp_pkg::OVERSAMPLE
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic bit_tick_in,
    input wire logic [asp_pkg::CTRL_W-1:0] ctrl_wdata_in,
    input wire logic ctrl_wr_in,
    input wire logic [7:0] buf_wdata_in,
    input wire logic buf_wr_in,
    input wire logic irq_enable_in,
    input wire logic serial_in_pin_in,
    output logic serial_out_pin_out,
    output logic [asp_pkg::CTRL_W-1:0] serial_control_out,
    output logic [7:0] serial_buffer_out,
    output logic irq_out
);
    import asp_pkg::*;

    localparam int unsigned CW = $clog2(OVS);
    localparam logic [CW-1:0] OVS_LAST = CW'(OVS - 1);
    // Mid-bit sample point scales with the oversample rate
    localparam logic [CW-1:0] SAMPLE_AT = CW'(SAMPLE_POINT * OVS / OVERSAMPLE);

    // Control register and receive buffer
    logic [CTRL_W-1:0] ctrl_q;
    logic [CTRL_W-1:0] ctrl_d;
    logic [7:0] rx_buf_q;
    logic [7:0] rx_buf_d;

    // Pin synchroniser
    logic rx_meta_q;
    logic rx_meta_d;
    logic rx_sync_q;
    logic rx_sync_d;

    // Transmitter
    asp_state_t tx_st_q;
    asp_state_t tx_st_d;
    logic [7:0] tx_sh_q;
    logic [7:0] tx_sh_d;
    logic [2:0] tx_cnt_q;
    logic [2:0] tx_cnt_d;
    logic [CW-1:0] tx_div_q;
    logic [CW-1:0] tx_div_d;
    logic tx_pin_q;
    logic tx_pin_d;
    logic tx_done_set;

    // Receiver
    asp_state_t rx_st_q;
    asp_state_t rx_st_d;
    logic [7:0] rx_sh_q;
    logic [7:0] rx_sh_d;
    logic [2:0] rx_cnt_q;
    logic [2:0] rx_cnt_d;
    logic [CW-1:0] rx_div_q;
    logic [CW-1:0] rx_div_d;
    logic rx_n9_q;
    logic rx_n9_d;
    logic rx_done_set;
    logic [7:0] rx_load_byte;
    logic rx_load_ninth;

    wire logic nine_mode = ctrl_q[FRAME_SEL_BIT];
    // Ticks are divided down so the receiver can centre its sample
    wire logic tx_bit_en = bit_tick_in && (tx_div_q == OVS_LAST);
    wire logic rx_sample = bit_tick_in && (rx_div_q == SAMPLE_AT);

    // Two flops before any logic reads the pin; reset to idle high so no false start
    always_comb begin
        rx_meta_d = serial_in_pin_in;
        rx_sync_d = rx_meta_q;
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            rx_meta_q <= 1'b1;
            rx_sync_q <= 1'b1;
        end else begin
            rx_meta_q <= rx_meta_d;
            rx_sync_q <= rx_sync_d;
        end
    end

    // Transmit sequencer
    always_comb begin
        tx_st_d = tx_st_q;
        tx_sh_d = tx_sh_q;
        tx_cnt_d = tx_cnt_q;
        tx_div_d = tx_div_q;
        tx_pin_d = tx_pin_q;
        tx_done_set = 1'b0;
        if (bit_tick_in) begin
            tx_div_d = (tx_div_q == OVS_LAST) ? '0 : tx_div_q + 1'b1;
        end
        unique case (tx_st_q)
            ASP_IDLE: begin
                tx_pin_d = 1'b1;
                if (buf_wr_in) begin
                    // Write alone launches the frame
                    tx_sh_d = buf_wdata_in;
                    tx_st_d = ASP_START;
                    tx_div_d = '0;
                    tx_pin_d = 1'b0;
                end
            end
            ASP_START: begin
                if (tx_bit_en) begin
                    tx_st_d = ASP_DATA;
                    tx_cnt_d = '0;
                    tx_pin_d = tx_sh_q[0];
                end
            end
            ASP_DATA: begin
                if (tx_bit_en) begin
                    tx_sh_d = {1'b0, tx_sh_q[7:1]};
                    tx_cnt_d = tx_cnt_q + 1'b1;
                    tx_pin_d = tx_sh_q[1];
                    if (tx_cnt_q == 3'(DATA_BITS - 1)) begin
                        if (nine_mode) begin
                            tx_st_d = ASP_NINTH;
                            // Taken from control as the last data bit ends
                            tx_pin_d = ctrl_q[TX_NINTH_BIT];
                        end else begin
                            tx_st_d = ASP_STOP;
                            tx_pin_d = 1'b1;
                            tx_done_set = 1'b1;
                        end
                    end
                end
            end
            ASP_NINTH: begin
                if (tx_bit_en) begin
                    tx_st_d = ASP_STOP;
                    tx_pin_d = 1'b1;
                    tx_done_set = 1'b1;
                end
            end
            ASP_STOP: begin
                if (tx_bit_en) begin
                    tx_st_d = ASP_IDLE;
                end
            end
            default: begin
                // Illegal state codes fall back to idle
                tx_st_d = ASP_IDLE;
                tx_pin_d = 1'b1;
            end
        endcase
    end

    // Receive sequencer, samples mid-bit
    always_comb begin
        rx_st_d = rx_st_q;
        rx_sh_d = rx_sh_q;
        rx_cnt_d = rx_cnt_q;
        rx_div_d = rx_div_q;
        rx_n9_d = rx_n9_q;
        rx_done_set = 1'b0;
        rx_load_byte = rx_sh_q;
        rx_load_ninth = rx_n9_q;
        if (bit_tick_in) begin
            rx_div_d = (rx_div_q == OVS_LAST) ? '0 : rx_div_q + 1'b1;
        end
        unique case (rx_st_q)
            ASP_IDLE: begin
                if (ctrl_q[RX_EN_BIT] && !rx_sync_q) begin
                    rx_st_d = ASP_START;
                    rx_div_d = '0;
                end
            end
            ASP_START: begin
                if (rx_sample) begin
                    // A glitch shorter than half a bit is not a start
                    rx_st_d = rx_sync_q ? ASP_IDLE : ASP_DATA;
                    rx_cnt_d = '0;
                end
            end
            ASP_DATA: begin
                if (rx_sample) begin
                    rx_sh_d = {rx_sync_q, rx_sh_q[7:1]};
                    rx_cnt_d = rx_cnt_q + 1'b1;
                    if (rx_cnt_q == 3'(DATA_BITS - 1)) begin
                        rx_st_d = nine_mode ? ASP_NINTH : ASP_STOP;
                    end
                end
            end
            ASP_NINTH: begin
                if (rx_sample) begin
                    rx_n9_d = rx_sync_q;
                    rx_st_d = ASP_STOP;
                end
            end
            ASP_STOP: begin
                if (rx_sample) begin
                    rx_st_d = ASP_IDLE;
                    // Stop bit is the ninth bit only in 8-bit framing
                    rx_load_ninth = nine_mode ? rx_n9_q : rx_sync_q;
                    // Full flag or failed address match drops the frame
                    if (!ctrl_q[RX_DONE_BIT] && (!ctrl_q[MP_EN_BIT] || rx_load_ninth)) begin
                        rx_done_set = 1'b1;
                    end
                end
            end
            default: begin
                // Illegal state codes fall back to idle
                rx_st_d = ASP_IDLE;
            end
        endcase
        // Clearing rx_enable drops a frame in flight, so nothing lands afterwards
        if (!ctrl_q[RX_EN_BIT]) begin
            rx_st_d = ASP_IDLE;
            rx_done_set = 1'b0;
        end
    end

    // Control bits and receive buffer; hardware sets beat software clears
    always_comb begin
        ctrl_d = ctrl_q;
        rx_buf_d = rx_buf_q;
        if (ctrl_wr_in) begin
            ctrl_d = ctrl_wdata_in;
        end
        if (tx_done_set) begin
            ctrl_d[TX_DONE_BIT] = 1'b1;
        end
        if (rx_done_set) begin
            rx_buf_d = rx_load_byte;
            ctrl_d[RX_NINTH_BIT] = rx_load_ninth;
            ctrl_d[RX_DONE_BIT] = 1'b1;
        end
    end

    // Control and receive buffer registers
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            ctrl_q <= CTRL_RESET;
            rx_buf_q <= BUF_RESET;
        end else begin
            ctrl_q <= ctrl_d;
            rx_buf_q <= rx_buf_d;
        end
    end

    // Transmit registers; the line idles high out of reset
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            tx_st_q <= ASP_IDLE;
            tx_sh_q <= '0;
            tx_cnt_q <= '0;
            tx_div_q <= '0;
            tx_pin_q <= 1'b1;
        end else begin
            tx_st_q <= tx_st_d;
            tx_sh_q <= tx_sh_d;
            tx_cnt_q <= tx_cnt_d;
            tx_div_q <= tx_div_d;
            tx_pin_q <= tx_pin_d;
        end
    end

    // Receive registers
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            rx_st_q <= ASP_IDLE;
            rx_sh_q <= '0;
            rx_cnt_q <= '0;
            rx_div_q <= '0;
            rx_n9_q <= 1'b0;
        end else begin
            rx_st_q <= rx_st_d;
            rx_sh_q <= rx_sh_d;
            rx_cnt_q <= rx_cnt_d;
            rx_div_q <= rx_div_d;
            rx_n9_q <= rx_n9_d;
        end
    end

    assign serial_out_pin_out = tx_pin_q;
    assign serial_control_out = ctrl_q;
    assign serial_buffer_out = rx_buf_q;
    // Level request: stays up while irq_enable_in is 1 until software clears both flags
    assign irq_out = irq_enable_in && (ctrl_q[TX_DONE_BIT] || ctrl_q[RX_DONE_BIT]);
endmodule
`default_nettype wire

// *** sim/asp_serial_port_monitor.sv ***
// Port checker for the asynchronous serial port
`timescale 1ns/100ps
`default_nettype none
module asp_serial_port_monitor #(
    parameter int unsigned OVS = 16
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] ctrl_wdata_in,
    input wire logic ctrl_wr_in,
    input wire logic irq_enable_in,
    input wire logic serial_out_pin_out,
    input wire logic [7:0] serial_control_out,
    input wire logic [7:0] serial_buffer_out,
    input wire logic irq_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    // Flags set by hardware, software writes excluded
    sequence hw_rx;
        $rose(serial_control_out[0]) && !$past(ctrl_wr_in);
    endsequence
    sequence hw_tx;
        $rose(serial_control_out[1]) && !$past(ctrl_wr_in);
    endsequence
    AST_IRQ: assert property (irq_out == (irq_enable_in && |serial_control_out[1:0]))
        else $error("irq level wrong");
    AST_CTRL_WR: assert property (ctrl_wr_in |=> serial_control_out[7:3] == $past(ctrl_wdata_in[7:3]))
        else $error("control write lost");
    AST_CTRL_HOLD: assert property (!ctrl_wr_in |=> $stable(serial_control_out[7:3]))
        else $error("control bits moved");
    AST_TX_DONE: assert property (hw_tx |-> serial_out_pin_out [*6])
        else $error("tx flag not at stop bit");
    AST_RX_LOAD: assert property (!$stable(serial_buffer_out) |-> $rose(serial_control_out[0]))
        else $error("buffer changed without flag");
    AST_RX_OVR: assert property (serial_control_out[0] |=> $stable(serial_buffer_out))
        else $error("buffer overwritten");
    AST_RX_EN: assert property (hw_rx |-> serial_control_out[4])
        else $error("frame taken while disabled");
    AST_RX_MP: assert property (hw_rx ##0 serial_control_out[5] |-> serial_control_out[2])
        else $error("filter let frame through");
    cover property (hw_tx);
    cover property (hw_rx ##0 serial_control_out[7]);
    cover property ($rose(irq_out));
    cover property (hw_rx ##0 (serial_control_out[5] && !serial_control_out[7]));
endmodule
`default_nettype wire

// *** sim/asp_peer.sv ***
// Remote serial node model
`timescale 1ns/100ps
`default_nettype none
module asp_peer #(
    parameter int BIT = 32
) (
    input wire logic mclk_in,
    input wire logic line_in,
    output logic line_out
);
    initial line_out = 1'b1;
    task automatic send(input logic [8:0] w, input bit nine);
        logic [10:0] f;
        f = nine ? {1'b1, w, 1'b0} : {2'b11, w[7:0], 1'b0};
        for (int i = 0; i < (nine ? 11 : 10); i++) begin
            line_out <= f[i];
            repeat (BIT) @(posedge mclk_in);
        end
    endtask
    // Samples mid bit; all unknown on a missing start bit
    task automatic recv(output logic [8:0] w, input bit nine);
        int n;
        w = 'x;
        n = 0;
        while (line_in !== 1'b0 && n < 200) begin
            @(posedge mclk_in);
            n++;
        end
        if (n == 200) return;
        repeat (BIT / 2) @(posedge mclk_in);
        for (int i = 0; i < (nine ? 9 : 8); i++) begin
            repeat (BIT) @(posedge mclk_in);
            w[i] = line_in;
        end
    endtask
endmodule
`default_nettype wire

// *** sim/asp_serial_port_tb.sv ***
// Self-checking bench for the asynchronous serial port
`timescale 1ns/100ps
`default_nettype none
module asp_serial_port_tb;
    localparam int BIT = 32;
    logic mclk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic bit_tick_in = 1'b0;
    logic [7:0] ctrl_wdata_in = 8'h00;
    logic ctrl_wr_in = 1'b0;
    logic [7:0] buf_wdata_in = 8'h00;
    logic buf_wr_in = 1'b0;
    logic irq_enable_in = 1'b0;
    wire logic serial_in_pin_in;
    logic serial_out_pin_out;
    logic [7:0] serial_control_out;
    logic [7:0] serial_buffer_out;
    logic irq_out;
    logic [8:0] w;
    int error_cnt = 0;
    int cmp_count = 0;
    always #2.5 mclk_in = ~mclk_in;
    always @(posedge mclk_in) bit_tick_in <= ~bit_tick_in;
    asp_serial_port #(.OVS(16)) dut_u (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .bit_tick_in(bit_tick_in),
        .ctrl_wdata_in(ctrl_wdata_in), .ctrl_wr_in(ctrl_wr_in), .buf_wdata_in(buf_wdata_in),
        .buf_wr_in(buf_wr_in), .irq_enable_in(irq_enable_in), .serial_in_pin_in(serial_in_pin_in),
        .serial_out_pin_out(serial_out_pin_out), .serial_control_out(serial_control_out),
        .serial_buffer_out(serial_buffer_out), .irq_out(irq_out));
    asp_peer #(.BIT(BIT)) peer_u (.mclk_in(mclk_in), .line_in(serial_out_pin_out), .line_out(serial_in_pin_in));
    task automatic tally_and_finish();
        $display("mismatches %0d comparisons %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wctl(input logic [7:0] v);
        @(posedge mclk_in);
        ctrl_wdata_in <= v;
        ctrl_wr_in <= 1'b1;
        @(posedge mclk_in);
        ctrl_wr_in <= 1'b0;
    endtask
    // Transmit one frame and decode it at the peer
    task automatic txchk(input logic [7:0] ctl, input logic [8:0] d);
        wctl(ctl);
        @(posedge mclk_in);
        buf_wdata_in <= d[7:0];
        buf_wr_in <= 1'b1;
        @(posedge mclk_in);
        buf_wr_in <= 1'b0;
        peer_u.recv(w, ctl[7]);
        if (w[7:0] === 8'hxx) begin
            $display("CHECK FAILED tx start expected frame seen timeout");
            error_cnt++;
            tally_and_finish();
        end
        chk("flag before stop", 16'h0000, {15'h0000, serial_control_out[1]});
        if (!ctl[7]) w[8] = d[8];
        chk("tx word", {7'h00, d}, {7'h00, w});
        repeat (BIT / 2 + 2) @(posedge mclk_in);
        chk("stop and flag", 16'h0003, {14'h0000, serial_out_pin_out, serial_control_out[1]});
        repeat (BIT) @(posedge mclk_in);
    endtask
    task automatic rxchk(input logic [8:0] d, input bit nine, input logic [15:0] exp);
        peer_u.send(d, nine);
        repeat (4) @(posedge mclk_in);
        chk("control and buffer", exp, {serial_control_out, serial_buffer_out});
    endtask
    task automatic t_tx();
        txchk(8'h00, 9'h0A5);
        txchk(8'h88, 9'h13C);
        txchk(8'h80, 9'h0C3);
    endtask
    task automatic t_rx8();
        wctl(8'h10);
        rxchk(9'h05A, 1'b0, 16'h155A);
        rxchk(9'h011, 1'b0, 16'h155A);
        chk("irq on", 16'h0001, {15'h0000, irq_out});
        irq_enable_in <= 1'b0;
        @(posedge mclk_in);
        @(posedge mclk_in);
        chk("irq masked", 16'h0000, {15'h0000, irq_out});
        wctl(8'h30);
        rxchk(9'h1C6, 1'b0, 16'h35C6);
    endtask
    task automatic t_rx9();
        wctl(8'hB0);
        rxchk(9'h077, 1'b1, 16'hB0C6);
        rxchk(9'h142, 1'b1, 16'hB542);
        wctl(8'h90);
        rxchk(9'h0E7, 1'b1, 16'h91E7);
        wctl(8'h80);
        rxchk(9'h099, 1'b1, 16'h80E7);
    endtask
    // Reset in mid frame puts the line and all bits back to idle
    task automatic t_reset();
        wctl(8'h10);
        @(posedge mclk_in);
        buf_wdata_in <= 8'h3C;
        buf_wr_in <= 1'b1;
        @(posedge mclk_in);
        buf_wr_in <= 1'b0;
        repeat (BIT * 2) @(posedge mclk_in);
        chk("line mid frame", 16'h0000, {15'h0000, serial_out_pin_out});
        rst_n_in <= 1'b0;
        repeat (3) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        repeat (2) begin
            @(posedge mclk_in);
            chk("reset again", 16'h0001, {serial_control_out, serial_buffer_out[7:1], serial_out_pin_out});
        end
        txchk(8'h00, 9'h05A);
    endtask
    initial begin
        repeat (20) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        irq_enable_in <= 1'b1;
        @(posedge mclk_in);
        chk("reset", 16'h0001, {serial_control_out, serial_buffer_out[7:1], serial_out_pin_out});
        @(posedge mclk_in);
        chk("reset settled", 16'h0001, {serial_control_out, serial_buffer_out[7:1], serial_out_pin_out});
        t_tx();
        t_rx8();
        t_rx9();
        t_reset();
        tally_and_finish();
    end
endmodule
bind asp_serial_port asp_serial_port_monitor #(.OVS(OVS)) mon_u (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .ctrl_wdata_in(ctrl_wdata_in), .ctrl_wr_in(ctrl_wr_in), .irq_enable_in(irq_enable_in),
    .serial_out_pin_out(serial_out_pin_out), .serial_control_out(serial_control_out),
    .serial_buffer_out(serial_buffer_out), .irq_out(irq_out));
`default_nettype wire
